//--- hdl/aesacc_consts.vh
// constants for the aes field multiplier and substitution helper
`ifndef AESACC_CONSTS_VH
`define AESACC_CONSTS_VH

// register offsets on the special function register port
`define AESACC_GF_MULTIPLY_DATA_ADDR 8'h84
`define AESACC_GF_MULTIPLY_CONSTANT_ADDR 8'h85
`define AESACC_SUBSTITUTION_DATA_ADDR 8'h86

// reset value of every register
`define AESACC_RESET_BYTE 8'h00

// reduction polynomial x^8+x^4+x^3+x+1, low byte
`define AESACC_POLY 8'h1b

// affine constants of the forward and inverse substitution
`define AESACC_AFFINE_FWD 8'h63
`define AESACC_AFFINE_INV 8'h05

// direction select values
`define AESACC_DIR_ENCRYPT 1'b0
`define AESACC_DIR_DECRYPT 1'b1

// unmapped reads return this
`define AESACC_UNMAPPED_BYTE 8'h00

`endif

//--- hdl/aesacc_sbox.v
// combinational forward and inverse aes substitution of one byte
`include "aesacc_consts.vh"

module aesacc_sbox (
    // conversion input
    input wire [7:0] in_byte,
    input wire decrypt,
    // conversion result
    output reg [7:0] out_byte
);

    function [7:0] gf_mul;
        input [7:0] a;
        input [7:0] b;
        reg [7:0] acc;
        reg [7:0] sh;
        integer i;
        begin
            acc = 8'h00;
            sh = a;
            for (i = 0; i < 8; i = i + 1) begin
                if (b[i]) begin
                    acc = acc ^ sh;
                end
                sh = sh[7] ? ({sh[6:0], 1'b0} ^ `AESACC_POLY) : {sh[6:0], 1'b0};
            end
            gf_mul = acc;
        end
    endfunction

    // x^254 is the field inverse, and maps zero to zero as the tables do
    function [7:0] gf_inv;
        input [7:0] x;
        reg [7:0] t;
        integer i;
        begin
            t = x;
            for (i = 0; i < 6; i = i + 1) begin
                t = gf_mul(gf_mul(t, t), x);
            end
            gf_inv = gf_mul(t, t);
        end
    endfunction

    function [7:0] rotl;
        input [7:0] x;
        input integer n;
        begin
            rotl = (x << n) | (x >> (8 - n));
        end
    endfunction

    reg [7:0] inv_in;
    reg [7:0] fwd_inv;

    // computed rather than tabled: two 256-entry tables cost far more area
    always @* begin
        fwd_inv = gf_inv(in_byte);
        inv_in = rotl(in_byte, 1) ^ rotl(in_byte, 3) ^ rotl(in_byte, 6) ^ `AESACC_AFFINE_INV;
        if (decrypt == `AESACC_DIR_DECRYPT) begin
            out_byte = gf_inv(inv_in); // see RULE9 see RULE13 see RULE14
        end else begin
            out_byte = fwd_inv ^ rotl(fwd_inv, 1) ^ rotl(fwd_inv, 2) ^ rotl(fwd_inv, 3)
                ^ rotl(fwd_inv, 4) ^ `AESACC_AFFINE_FWD; // see RULE9 see RULE13 see RULE14
        end
    end

endmodule

//--- hdl/aesacc_top.v
// aes helper: field multiplier and substitution unit behind the sfr port
`include "aesacc_consts.vh"

// Summary of operation
// RULE1 - multiply stored constant byte by written data byte in the aes field
// RULE2 - constant register changes only when software writes it
// RULE3 - each data register write starts one field multiplication
// RULE4 - product ready two clocks after the write, replacing the operand
// RULE5 - after completion, reading the data register returns the product
// RULE6 - result is captured one clock after the write is registered
// RULE7 - software loads the constant before the data when it must change
// RULE8 - software waits at least one instruction before reading the product
// RULE9 - substitution uses forward box for encryption, inverse box for decryption
// RULE10 - each substitution data write starts one conversion replacing the register
// RULE11 - conversion readable two clocks after the substitution data write
// RULE12 - software waits at least one instruction before reading the converted byte
// RULE13 - direction zero selects forward box, one selects inverse box
// RULE14 - reduce by x^8+x^4+x^3+x+1; boxes match the aes standard exactly
// RULE15 - early reads return previous contents; the processor is never stalled
module aesacc_top #(
    parameter DATA_WIDTH = 8
) (
    // clock and reset
    input wire core_clk,
    input wire reset,
    // special function register port
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire [7:0] sfr_wdata,
    input wire sfr_rd,
    output reg [7:0] sfr_rdata,
    output reg sfr_rd_hit,
    // direction bit from the system settings register
    input wire system_settings_decrypt,
    // operation in flight, for observation
    output wire gfm_busy,
    output wire sbox_busy
);

    // register state
    reg [7:0] gf_multiply_data;
    reg [7:0] gf_multiply_constant;
    reg [7:0] substitution_data;
    reg gfm_pending;
    reg sbox_pending;

    // decoded addresses and strobes
    wire sel_gf_multiply_data;
    wire sel_gf_multiply_constant;
    wire sel_substitution_data;
    wire wr_gf_multiply_data;
    wire wr_gf_multiply_constant;
    wire wr_substitution_data;

    assign sel_gf_multiply_data = (sfr_addr == `AESACC_GF_MULTIPLY_DATA_ADDR);
    assign sel_gf_multiply_constant = (sfr_addr == `AESACC_GF_MULTIPLY_CONSTANT_ADDR);
    assign sel_substitution_data = (sfr_addr == `AESACC_SUBSTITUTION_DATA_ADDR);
    // write strobes; a write to any other address is dropped
    assign wr_gf_multiply_data = sfr_wr && sel_gf_multiply_data;
    assign wr_gf_multiply_constant = sfr_wr && sel_gf_multiply_constant;
    assign wr_substitution_data = sfr_wr && sel_substitution_data;

    // busy is a handshake-like output, taken straight from the pending flags
    assign gfm_busy = gfm_pending;
    assign sbox_busy = sbox_pending;

    // ---- field multiplier: shift-and-add, one stage per constant bit ----
    wire [7:0] mul_shift [0:DATA_WIDTH];
    wire [7:0] mul_acc [0:DATA_WIDTH];

    assign mul_shift[0] = gf_multiply_data;
    assign mul_acc[0] = `AESACC_RESET_BYTE;

    genvar gi;
    generate
        for (gi = 0; gi < DATA_WIDTH; gi = gi + 1) begin : g_mul
            wire stage_carry;
            wire [7:0] stage_double;
            // partial product of this constant bit
            assign mul_acc[gi + 1] = gf_multiply_constant[gi]
                ? (mul_acc[gi] ^ mul_shift[gi]) : mul_acc[gi]; // see RULE1
            // multiply by x, reducing when the top bit falls out
            assign stage_carry = mul_shift[gi][DATA_WIDTH - 1];
            assign stage_double = {mul_shift[gi][DATA_WIDTH - 2:0], 1'b0};
            assign mul_shift[gi + 1] = stage_carry
                ? (stage_double ^ `AESACC_POLY) : stage_double; // see RULE14
        end
    endgenerate

    wire [7:0] gfm_product;

    assign gfm_product = mul_acc[DATA_WIDTH];

    // ---- substitution unit ----
    wire [7:0] sbox_result;

    aesacc_sbox u_sbox (
        .in_byte(substitution_data),
        .decrypt(system_settings_decrypt),
        .out_byte(sbox_result)
    );

    // ---- next values of the operation registers ----
    reg [7:0] next_gf_multiply_constant;
    reg [7:0] next_gf_multiply_data;
    reg next_gfm_pending;
    reg [7:0] next_substitution_data;
    reg next_sbox_pending;

    // the constant is read at the capture edge, so it must be loaded first
    always @* begin
        next_gf_multiply_constant = gf_multiply_constant;
        if (wr_gf_multiply_constant) begin
            next_gf_multiply_constant = sfr_wdata; // see RULE2 see RULE7
        end
    end

    // a fresh write in the capture cycle wins and restarts the operation
    always @* begin
        next_gf_multiply_data = gf_multiply_data;
        next_gfm_pending = 1'b0;
        if (wr_gf_multiply_data) begin
            next_gf_multiply_data = sfr_wdata; // see RULE3
            next_gfm_pending = 1'b1; // see RULE3
        end else if (gfm_pending) begin
            next_gf_multiply_data = gfm_product; // see RULE4 see RULE5 see RULE6
        end
    end

    // direction is sampled at the capture edge, not at the write
    always @* begin
        next_substitution_data = substitution_data;
        next_sbox_pending = 1'b0;
        if (wr_substitution_data) begin
            next_substitution_data = sfr_wdata; // see RULE10
            next_sbox_pending = 1'b1; // see RULE10
        end else if (sbox_pending) begin
            next_substitution_data = sbox_result; // see RULE10 see RULE11
        end
    end

    // ---- operation registers ----
    always @(posedge core_clk) begin
        if (reset) begin
            gf_multiply_constant <= `AESACC_RESET_BYTE;
        end else begin
            gf_multiply_constant <= next_gf_multiply_constant;
        end
    end

    // the product settles within one cycle, so no extra pipeline stage is kept
    always @(posedge core_clk) begin
        if (reset) begin
            gf_multiply_data <= `AESACC_RESET_BYTE;
            gfm_pending <= 1'b0;
        end else begin
            gf_multiply_data <= next_gf_multiply_data;
            gfm_pending <= next_gfm_pending;
        end
    end

    // pending flags drop on their own, so no software clear can race a set
    always @(posedge core_clk) begin
        if (reset) begin
            substitution_data <= `AESACC_RESET_BYTE;
            sbox_pending <= 1'b0;
        end else begin
            substitution_data <= next_substitution_data;
            sbox_pending <= next_sbox_pending;
        end
    end

    // ---- read path ----
    reg [7:0] next_rdata;
    reg next_hit;
    reg [7:0] next_sfr_rdata;
    reg next_sfr_rd_hit;

    // no wait state exists: an early read simply sees the operand
    always @* begin
        next_rdata = `AESACC_UNMAPPED_BYTE;
        next_hit = 1'b0;
        case (sfr_addr)
            `AESACC_GF_MULTIPLY_DATA_ADDR: begin
                next_rdata = gf_multiply_data; // see RULE5 see RULE15
                next_hit = 1'b1;
            end
            `AESACC_GF_MULTIPLY_CONSTANT_ADDR: begin
                next_rdata = gf_multiply_constant;
                next_hit = 1'b1;
            end
            `AESACC_SUBSTITUTION_DATA_ADDR: begin
                next_rdata = substitution_data; // see RULE11 see RULE15
                next_hit = 1'b1;
            end
            default: begin
                next_rdata = `AESACC_UNMAPPED_BYTE;
                next_hit = 1'b0;
            end
        endcase
    end

    // read data holds until the next read strobe; the hit flag lasts one cycle
    always @* begin
        next_sfr_rdata = sfr_rdata;
        next_sfr_rd_hit = 1'b0;
        if (sfr_rd) begin
            next_sfr_rdata = next_rdata; // see RULE8 see RULE12
            next_sfr_rd_hit = next_hit;
        end
    end

    // registered so the core samples a settled byte, at one cycle of latency
    always @(posedge core_clk) begin
        if (reset) begin
            sfr_rdata <= `AESACC_RESET_BYTE;
            sfr_rd_hit <= 1'b0;
        end else begin
            sfr_rdata <= next_sfr_rdata;
            sfr_rd_hit <= next_sfr_rd_hit;
        end
    end

endmodule

//--- dv/aesacc_assertions.sv
// property checker on the aes helper ports
module aesacc_checker (
    // clock and reset
    input wire core_clk,
    input wire reset,
    // sfr port and status
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire [7:0] sfr_wdata,
    input wire sfr_rd,
    input wire [7:0] sfr_rdata,
    input wire sfr_rd_hit,
    input wire system_settings_decrypt,
    input wire gfm_busy,
    input wire sbox_busy
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    wire gw = sfr_wr && sfr_addr == 8'h84;
    wire sw = sfr_wr && sfr_addr == 8'h86;
    wire map = sfr_addr >= 8'h84 && sfr_addr <= 8'h86;
    property p_gbusy; gw |=> gfm_busy; endproperty
    property p_gdone; gfm_busy && !gw |=> !gfm_busy; endproperty
    property p_sbusy; sw |=> sbox_busy; endproperty
    property p_sdone; sbox_busy && !sw |=> !sbox_busy; endproperty
    property p_hit; sfr_rd && map |=> sfr_rd_hit; endproperty
    property p_miss; sfr_rd && !map |=> !sfr_rd_hit && sfr_rdata == 8'h00; endproperty
    property p_hold; !sfr_rd |=> $stable(sfr_rdata) && !sfr_rd_hit; endproperty
    // read right after the write still sees the operand
    property p_early; gw ##1 (sfr_rd && sfr_addr == 8'h84 && !sfr_wr)
        |=> sfr_rdata == $past(sfr_wdata, 2); endproperty
    a_gbusy: assert property (p_gbusy) else $error("no gfm busy");
    a_gdone: assert property (p_gdone) else $error("gfm late");
    a_sbusy: assert property (p_sbusy) else $error("no sbox busy");
    a_sdone: assert property (p_sdone) else $error("sbox late");
    a_hit: assert property (p_hit) else $error("no read hit");
    a_miss: assert property (p_miss) else $error("bad unmapped read");
    a_hold: assert property (p_hold) else $error("read data moved");
    a_early: assert property (p_early) else $error("early read");
    c_gfm: cover property (gw);
    c_dec: cover property (sw && system_settings_decrypt);
    c_miss: cover property (sfr_rd && !map);
    c_restart: cover property (gfm_busy && gw);
endmodule

//--- dv/tb_aesacc_top.sv
// self-checking bench for the aes helper
module tb_aesacc_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, reset, sfr_wr, sfr_rd, dec, hit, gb, sb, rd_seen;
    logic [7:0] sfr_addr, sfr_wdata, rdata, c, d, x;
    logic [8:0] q[$];
    logic [31:0] s = 41;
    int errors = 0;
    int n_tests = 0;
    aesacc_top uut (.core_clk(core_clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(rdata), .sfr_rd_hit(hit),
        .system_settings_decrypt(dec), .gfm_busy(gb), .sbox_busy(sb));
    initial begin
        core_clk = 0;
        forever #50 core_clk = ~core_clk;
    end
    function automatic logic [7:0] rnd;
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s[7:0];
    endfunction
    function automatic logic [7:0] gm(input logic [7:0] a, b);
        logic [7:0] p;
        p = 8'h00;
        repeat (8) begin
            if (b[0]) p ^= a;
            a = {a[6:0], 1'b0} ^ (a[7] ? 8'h1b : 8'h00);
            b >>= 1;
        end
        return p;
    endfunction
    // x^254 gives the field inverse, zero maps to zero
    function automatic logic [7:0] fwd(input logic [7:0] x);
        logic [7:0] p;
        p = 8'h01;
        repeat (254) p = gm(p, x);
        return p ^ {p[6:0], p[7]} ^ {p[5:0], p[7:6]} ^ {p[4:0], p[7:5]} ^ {p[3:0], p[7:4]} ^ 8'h63;
    endfunction
    // inverse box filled by inverting the forward model once, independent of the design
    logic [7:0] inv [256];
    task automatic check(input string name, input logic [8:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    task op(input logic [7:0] a, v, input logic w, r);
        sfr_addr = a;
        sfr_wdata = v;
        sfr_wr = w;
        sfr_rd = r;
        @(negedge core_clk);
    endtask
    task rd(input logic [7:0] a, input logic [8:0] e);
        q.push_back(e);
        op(a, rnd(), 0, 1);
    endtask
    task print_verdict;
        $display("comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(posedge core_clk) rd_seen <= sfr_rd && !reset;
    always @(negedge core_clk) begin
        if (rd_seen) check("sfr read", {hit, rdata}, q.pop_front());
    end
    initial begin
        repeat (4000) @(posedge core_clk);
        errors++;
        print_verdict;
    end
    initial begin
        reset = 1;
        {sfr_wr, sfr_rd, dec, sfr_addr, sfr_wdata} = '0;
        repeat (12) @(negedge core_clk);
        reset = 0;
        for (int a = 8'h83; a < 8'h88; a++) rd(a[7:0], {a > 8'h83 && a < 8'h87, 8'h00});
        $display("reset values done");
        for (int i = 0; i < 20; i++) begin
            if (i % 2 == 0) begin
                c = i == 0 ? 8'h02 : rnd();
                op(8'h85, c, 1, 0);
            end
            d = i == 0 ? 8'h87 : rnd();
            op(8'h84, d, 1, 0);
            check("busy flags", {gb, sb}, 2'h2);
            if (i % 2) rd(8'h84, {1'b1, d});
            else op(rnd(), rnd(), 0, 0);
            rd(8'h84, {1'b1, gm(d, c)});
            rd(8'h85, {1'b1, c});
        end
        op(8'h84, rnd(), 1, 0);
        d = rnd();
        op(8'h84, d, 1, 0);
        op(rnd(), rnd(), 0, 0);
        rd(8'h84, {1'b1, gm(d, c)});
        op(8'h87, rnd(), 1, 0);
        rd(8'h85, {1'b1, c});
        $display("field multiply done");
        for (int j = 0; j < 256; j++) inv[fwd(j[7:0])] = j[7:0];
        for (int i = 0; i < 12; i++) begin
            dec = i[0];
            x = i == 0 ? 8'h00 : (i == 1 ? 8'h63 : rnd());
            op(8'h86, x, 1, 0);
            check("busy flags", {gb, sb}, 2'h1);
            op(rnd(), rnd(), 0, 0);
            rd(8'h86, {1'b1, i[0] ? inv[x] : fwd(x)});
        end
        op(8'h00, 8'h00, 0, 0);
        $display("substitution done");
        print_verdict;
    end
endmodule
bind aesacc_top aesacc_checker chk (.core_clk(core_clk), .reset(reset), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .sfr_rd_hit(sfr_rd_hit), .system_settings_decrypt(system_settings_decrypt),
    .gfm_busy(gfm_busy), .sbox_busy(sbox_busy));
